// *** core/swp_pkg.sv ***
/*
 * Shared constants for the serial flash write-protection block: command
 * codes, frame lengths, field positions, reset values and timing.
 * Assumes a 100 MHz system clock and a mode 0/3 serial link.
 */
package swp_pkg;

	// command codes (plain defaults, no particular part implied)
	localparam logic [7:0] OP_WRITE_ALLOW = 8'h06;
	localparam logic [7:0] OP_WRITE_DISALLOW = 8'h04;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OP_AUTO_INC_WRITE = 8'hAD;
	localparam logic [7:0] OP_FOUR_K_WIPE = 8'h20;
	localparam logic [7:0] OP_BLOCK_WIPE = 8'hD8;
	localparam logic [7:0] OP_CHIP_WIPE = 8'hC7;
	localparam logic [7:0] OP_SLEEP = 8'hB9;
	localparam logic [7:0] OP_WAKE = 8'hAB;
	localparam logic [7:0] OP_OTP_ENTRY = 8'hB1;
	localparam logic [7:0] OP_OTP_EXIT = 8'hC1;
	localparam logic [7:0] OP_SEC_REG_WRITE = 8'h2F;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_DUAL_READ = 8'hBB;
	localparam logic [7:0] OP_QUAD_READ = 8'hEB;

	// frame lengths in serial clocks
	localparam logic [11:0] LEN_OPCODE = 12'h008;
	localparam logic [11:0] LEN_STATUS = 12'h010;
	localparam logic [11:0] LEN_ADDR = 12'h020;
	localparam logic [11:0] LEN_MAX = 12'hFFF;
	localparam logic [11:0] RD_SINGLE_START = 12'h020;
	localparam logic [11:0] RD_FAST_START = 12'h028;
	localparam logic [11:0] RD_DUAL_START = 12'h018;
	localparam logic [11:0] RD_QUAD_START = 12'h014;

	// status byte and address fields
	localparam int SR_BP_LSB = 2;
	localparam int SR_GUARD_BIT = 7;
	localparam int ADDR_BLOCK_LSB = 16;
	localparam logic [6:0] NUM_BLOCKS = 7'h40;
	localparam logic [3:0] RST_BP = 4'h0;
	localparam logic RST_GUARD = 1'b0;

	// otp area map and security register bits
	localparam logic [8:0] OTP_SERIAL_LAST = 9'h00F;
	localparam logic [8:0] OTP_CUST_FIRST = 9'h010;
	localparam logic [8:0] OTP_LAST = 9'h1FF;
	localparam int SEC_FACTORY_BIT = 0;
	localparam int SEC_CUST_BIT = 1;

	// wipe kinds
	localparam logic [1:0] WIPE_FOUR_K = 2'h0;
	localparam logic [1:0] WIPE_BLOCK = 2'h1;
	localparam logic [1:0] WIPE_CHIP = 2'h2;

	// timing
	localparam int MCLK_MHZ = 100;
	localparam int PUW_TIME_US = 10;
	localparam int PUW_CYCLES = PUW_TIME_US * MCLK_MHZ;

	// synchroniser lanes
	localparam int SYNC_CS = 0;
	localparam int SYNC_TOG = 1;
	localparam int SYNC_QUAD = 2;
	localparam int SYNC_PIN = 3;
	localparam int SYNC_FLOCK = 4;
	localparam int SYNC_CLOCK = 5;
	localparam int N_SYNC = 6;
	// idle levels: chip select and protect pin high, the rest low
	localparam logic [N_SYNC-1:0] SYNC_RST = 6'h09;

	typedef enum logic [1:0] {
		ST_START = 2'b00,
		ST_IDLE = 2'b01,
		ST_EVAL = 2'b11
	} swp_state_e;

endpackage

// *** core/swp_write_protect.sv ***
/*
 * Write-protection, deep-sleep filter and secured otp logic of a serial
 * flash. Link side runs on sclk; decisions run on mclk after the frame.
 * Assumes csN is high at start, sclk idles outside frames and the read,
 * program and erase datapaths sit outside this module.
 */
// Summary of operation
// - after power-up the command logic starts idle in read mode with no program or erase pending.
// - after reset program and erase stay blocked until the power-up write delay has run out.
// - a command runs only if chip select rises on a whole byte boundary, else it is discarded.
// - data-altering commands need the write latch set by write-allow and are refused while it is clear.
// - the write latch clears at power-up and on completion of write-disallow, status write, page write, word write and each wipe.
// - in deep sleep every command except wake-from-sleep (also the signature read) is ignored.
// - the four block-protect bits decode into top, bottom, all or no protected blocks.
// - with the guard bit set and the protect pin low, block-protect and guard bits cannot change.
// - during a four-line read the protect pin is data and pin guard mode is off.
// - in two-line and four-line reads the data lines turn bidirectional and are driven by the device.
// - security bit zero shows the factory lock of the otp area.
// - the security register write sets security bit one, locking the customer otp region.
// - once set, neither lock bit can be cleared or changed again.
// - otp entry redirects program accesses to the otp area until otp exit.
// - while otp mode is on, main array accesses are refused.
// - otp offsets 000 to 00F hold the factory serial number and 010 to 1FF the customer region.
module swp_write_protect
	import swp_pkg::*;
#(
	parameter int PUW_CYCLE_COUNT = PUW_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic csN,
	input wire logic dataLine0In,
	output logic dataLine0Out,
	output logic dataLine0Oe,
	input wire logic dataLine1In,
	output logic dataLine1Out,
	output logic dataLine1Oe,
	input wire logic protectPinOrDataLine2In,
	output logic protectPinOrDataLine2Out,
	output logic protectPinOrDataLine2Oe,
	input wire logic sparePinOrDataLine3In,
	output logic sparePinOrDataLine3Out,
	output logic sparePinOrDataLine3Oe,
	input wire logic [3:0] readNibble,
	input wire logic factoryLockStored,
	input wire logic customerLockStored,
	output logic writeLatch,
	output logic [3:0] blockProtectBits,
	output logic statusWriteGuard,
	output logic [1:0] securityBits,
	output logic otpMode,
	output logic deepSleep,
	output logic writesHeld,
	output logic pinGuardActive,
	output logic programStart,
	output logic eraseStart,
	output logic [1:0] eraseKind,
	output logic otpTarget,
	output logic [23:0] targetAddr,
	output logic cmdDiscarded,
	output logic cmdRefused
);

	// link domain
	logic inFrame;
	logic frameTog;
	logic [11:0] bitCount;
	logic [11:0] nextCount;
	logic [31:0] shiftIn;
	logic [7:0] cmdOpcode;
	logic [7:0] cmdStatus;
	logic [23:0] cmdAddr;
	logic sleepLink1;
	logic sleepLink2;
	logic quadFrame;

	// system domain
	logic [N_SYNC-1:0] asyncIn;
	logic [N_SYNC-1:0] syncMeta;
	logic [N_SYNC-1:0] syncOut;
	logic csPrev;
	logic togSeen;
	swp_state_e state;
	swp_state_e next_state;
	logic [23:0] puwCount;
	logic factoryLock;
	logic customerLock;

	// evaluation terms
	logic frameDone;
	logic byteOk;
	logic [11:0] needLen;
	logic isAltering;
	logic isProgram;
	logic isWipe;
	logic lengthOk;
	logic sleepOk;
	logic gateOk;
	logic areaOk;
	logic guardBlocks;
	logic [8:0] otpOffset;
	logic accept;
	logic grant;

	function automatic logic isProtected(input logic [3:0] code,
		input logic [5:0] blk);
		logic [6:0] edgeIdx;
		logic hit;
		edgeIdx = 7'h00;
		hit = 1'b0;
		if (code >= 4'h1 && code <= 4'h6) begin
			edgeIdx = NUM_BLOCKS - (7'h01 << (code - 4'h1));
			hit = {1'b0, blk} >= edgeIdx;
		end else if (code >= 4'h9 && code <= 4'hE) begin
			edgeIdx = NUM_BLOCKS - (7'h01 << (4'hE - code));
			hit = {1'b0, blk} < edgeIdx;
		end else begin
			hit = code != 4'h0;
		end
		return hit;
	endfunction

	// ---- link side: count clocks and capture opcode, status, address
	always_comb begin
		if (!inFrame) begin
			nextCount = 12'h001;
		end else if (bitCount == LEN_MAX) begin
			nextCount = LEN_MAX;
		end else begin
			nextCount = bitCount + 12'h001;
		end
	end

	// csN clears only the frame marker; the captured fields must outlive
	// the frame so the system side can judge it after chip select rises
	always_ff @(posedge sclk or posedge csN) begin
		if (csN) begin
			inFrame <= 1'b0;
		end else begin
			inFrame <= 1'b1;
		end
	end

	always_ff @(posedge sclk) begin
		bitCount <= nextCount;
		shiftIn <= {shiftIn[30:0], dataLine0In};
		if (nextCount == LEN_OPCODE) begin
			cmdOpcode <= {shiftIn[6:0], dataLine0In};
		end
		if (nextCount == LEN_STATUS) begin
			cmdStatus <= {shiftIn[6:0], dataLine0In};
		end
		if (nextCount == LEN_ADDR) begin
			cmdAddr <= {shiftIn[22:0], dataLine0In};
		end
	end

	// sclk stands still while rst is high, so rst may clear the toggle
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			frameTog <= 1'b0;
		end else if (!inFrame) begin
			frameTog <= ~frameTog;
		end
	end

	// sleep flag only changes between frames, so two edges settle it
	always_ff @(posedge sclk) begin
		sleepLink1 <= deepSleep;
		sleepLink2 <= sleepLink1;
	end

	// read data phase: lines turn around on the falling edge
	always_ff @(negedge sclk or posedge csN) begin
		if (csN) begin
			dataLine0Oe <= 1'b0;
			dataLine1Oe <= 1'b0;
			protectPinOrDataLine2Oe <= 1'b0;
			sparePinOrDataLine3Oe <= 1'b0;
			quadFrame <= 1'b0;
		end else begin
			quadFrame <= inFrame && bitCount >= LEN_OPCODE &&
				cmdOpcode == OP_QUAD_READ;
			dataLine0Oe <= 1'b0;
			dataLine1Oe <= 1'b0;
			protectPinOrDataLine2Oe <= 1'b0;
			sparePinOrDataLine3Oe <= 1'b0;
			// stale count of the last frame must not open a mode 3 frame
			if (!sleepLink2 && inFrame && bitCount >= LEN_OPCODE) begin
				case (cmdOpcode)
					OP_READ: begin
						dataLine1Oe <= bitCount >= RD_SINGLE_START;
					end
					OP_FAST_READ: begin
						dataLine1Oe <= bitCount >= RD_FAST_START;
					end
					OP_DUAL_READ: begin
						dataLine0Oe <= bitCount >= RD_DUAL_START;
						dataLine1Oe <= bitCount >= RD_DUAL_START;
					end
					OP_QUAD_READ: begin
						dataLine0Oe <= bitCount >= RD_QUAD_START;
						dataLine1Oe <= bitCount >= RD_QUAD_START;
						protectPinOrDataLine2Oe <=
							bitCount >= RD_QUAD_START;
						sparePinOrDataLine3Oe <=
							bitCount >= RD_QUAD_START;
					end
					default: begin
						dataLine0Oe <= 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(negedge sclk) begin
		dataLine0Out <= readNibble[0];
		dataLine1Out <= readNibble[1];
		protectPinOrDataLine2Out <= readNibble[2];
		sparePinOrDataLine3Out <= readNibble[3];
	end

	// ---- system side: chip select, toggle, quad flag, protect pin and stored locks pass two flops; the captured fields are read directly
	assign asyncIn = {customerLockStored, factoryLockStored,
		protectPinOrDataLine2In, quadFrame, frameTog, csN};

	generate
		for (genvar i = 0; i < N_SYNC; i++) begin : g_sync
			always_ff @(posedge mclk) begin
				if (rst) begin
					syncMeta[i] <= SYNC_RST[i];
					syncOut[i] <= SYNC_RST[i];
				end else begin
					syncMeta[i] <= asyncIn[i];
					syncOut[i] <= syncMeta[i];
				end
			end
		end
	endgenerate

	// a frame counts only if chip select rose and sclk toggled in it
	assign frameDone = syncOut[SYNC_CS] && !csPrev &&
		syncOut[SYNC_TOG] != togSeen;

	always_ff @(posedge mclk) begin
		if (rst) begin
			csPrev <= 1'b1;
			togSeen <= 1'b0;
		end else begin
			csPrev <= syncOut[SYNC_CS];
			if (state == ST_START || state == ST_EVAL) begin
				togSeen <= syncOut[SYNC_TOG];
			end
		end
	end

	always_comb begin
		case (state)
			ST_START: next_state = ST_IDLE;
			ST_IDLE: next_state = frameDone ? ST_EVAL : ST_IDLE;
			ST_EVAL: next_state = ST_IDLE;
			default: next_state = ST_START;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_START;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			puwCount <= 24'h000000;
			writesHeld <= 1'b1;
		end else if (writesHeld) begin
			puwCount <= puwCount + 24'h000001;
			writesHeld <= puwCount < 24'(PUW_CYCLE_COUNT - 1);
		end
	end

	// ---- judging a finished frame
	always_comb begin
		isProgram = cmdOpcode == OP_PAGE_WRITE ||
			cmdOpcode == OP_AUTO_INC_WRITE;
		isWipe = cmdOpcode == OP_FOUR_K_WIPE ||
			cmdOpcode == OP_BLOCK_WIPE || cmdOpcode == OP_CHIP_WIPE;
		isAltering = isProgram || isWipe ||
			cmdOpcode == OP_STATUS_WRITE ||
			cmdOpcode == OP_SEC_REG_WRITE;
		if (isProgram || cmdOpcode == OP_FOUR_K_WIPE ||
			cmdOpcode == OP_BLOCK_WIPE) begin
			needLen = LEN_ADDR;
		end else if (cmdOpcode == OP_STATUS_WRITE) begin
			needLen = LEN_STATUS;
		end else begin
			needLen = LEN_OPCODE;
		end
	end

	assign byteOk = bitCount[2:0] == 3'h0;
	assign lengthOk = byteOk && bitCount >= needLen;
	assign sleepOk = !deepSleep || cmdOpcode == OP_WAKE;
	assign accept = lengthOk && sleepOk;
	assign otpOffset = cmdAddr[8:0];

	// timer and latch gate every data-altering command
	assign gateOk = !writesHeld && writeLatch;

	// pin guard: guard bit set, pin low, and the pin not serving as data
	assign guardBlocks = statusWriteGuard && !syncOut[SYNC_PIN] &&
		!syncOut[SYNC_QUAD];

	always_comb begin
		areaOk = 1'b1;
		if (isProgram && otpMode) begin
			// otp offsets wrap within 000..1FF; upper address ignored
			areaOk = otpOffset <= OTP_SERIAL_LAST ?
				!factoryLock : !customerLock;
		end else if (isWipe && otpMode) begin
			areaOk = 1'b0;
		end else if (cmdOpcode == OP_CHIP_WIPE) begin
			areaOk = blockProtectBits == 4'h0;
		end else if (isProgram || isWipe) begin
			areaOk = !isProtected(blockProtectBits,
				cmdAddr[ADDR_BLOCK_LSB +: 6]);
		end else if (cmdOpcode == OP_STATUS_WRITE) begin
			areaOk = !guardBlocks;
		end
	end

	assign grant = state == ST_EVAL && accept &&
		(!isAltering || (gateOk && areaOk));

	always_ff @(posedge mclk) begin
		if (rst) begin
			writeLatch <= 1'b0;
		end else if (grant) begin
			if (cmdOpcode == OP_WRITE_ALLOW) begin
				writeLatch <= 1'b1;
			end else if (cmdOpcode == OP_WRITE_DISALLOW || isProgram ||
				isWipe || cmdOpcode == OP_STATUS_WRITE) begin
				writeLatch <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			blockProtectBits <= RST_BP;
			statusWriteGuard <= RST_GUARD;
		end else if (grant && cmdOpcode == OP_STATUS_WRITE) begin
			blockProtectBits <= cmdStatus[SR_BP_LSB +: 4];
			statusWriteGuard <= cmdStatus[SR_GUARD_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			deepSleep <= 1'b0;
			otpMode <= 1'b0;
		end else if (grant) begin
			if (cmdOpcode == OP_SLEEP) begin
				deepSleep <= 1'b1;
			end else if (cmdOpcode == OP_WAKE) begin
				deepSleep <= 1'b0;
			end
			if (cmdOpcode == OP_OTP_ENTRY) begin
				otpMode <= 1'b1;
			end else if (cmdOpcode == OP_OTP_EXIT) begin
				otpMode <= 1'b0;
			end
		end
	end

	// locks only ever set; stored copies come back after every reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			factoryLock <= 1'b0;
			customerLock <= 1'b0;
		end else begin
			factoryLock <= factoryLock | syncOut[SYNC_FLOCK];
			customerLock <= customerLock | syncOut[SYNC_CLOCK] |
				(grant && cmdOpcode == OP_SEC_REG_WRITE);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			securityBits <= 2'h0;
			pinGuardActive <= 1'b0;
		end else begin
			securityBits[SEC_FACTORY_BIT] <= factoryLock;
			securityBits[SEC_CUST_BIT] <= customerLock;
			pinGuardActive <= statusWriteGuard &&
				!syncOut[SYNC_QUAD];
		end
	end

	// one-cycle launches toward the program and erase engines
	always_ff @(posedge mclk) begin
		if (rst) begin
			programStart <= 1'b0;
			eraseStart <= 1'b0;
			eraseKind <= WIPE_FOUR_K;
			otpTarget <= 1'b0;
			targetAddr <= 24'h000000;
			cmdDiscarded <= 1'b0;
			cmdRefused <= 1'b0;
		end else begin
			programStart <= grant && isProgram;
			eraseStart <= grant && isWipe;
			cmdDiscarded <= state == ST_EVAL && !accept;
			cmdRefused <= state == ST_EVAL && accept && !grant;
			if (grant && (isProgram || isWipe)) begin
				otpTarget <= otpMode;
				targetAddr <= cmdAddr;
				if (cmdOpcode == OP_CHIP_WIPE) begin
					eraseKind <= WIPE_CHIP;
				end else if (cmdOpcode == OP_BLOCK_WIPE) begin
					eraseKind <= WIPE_BLOCK;
				end else begin
					eraseKind <= WIPE_FOUR_K;
				end
			end
		end
	end

	// unused inputs kept for pin symmetry; data enters on line 0 only
	logic unusedIn;
	assign unusedIn = dataLine1In ^ sparePinOrDataLine3In ^
		otpOffset[8] ^ OTP_CUST_FIRST[0] ^ OTP_LAST[0];

endmodule

// *** verif/swp_props.sv ***
/*
 * Port checker for swp_write_protect, bound to every instance.
 * Assumes one mclk domain and a synchronous active high rst.
 */
module swp_props
	import swp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic protectPinOrDataLine2In,
	input wire logic dataLine0Oe,
	input wire logic dataLine1Oe,
	input wire logic protectPinOrDataLine2Oe,
	input wire logic sparePinOrDataLine3Oe,
	input wire logic factoryLockStored,
	input wire logic writeLatch,
	input wire logic [3:0] blockProtectBits,
	input wire logic statusWriteGuard,
	input wire logic [1:0] securityBits,
	input wire logic otpMode,
	input wire logic deepSleep,
	input wire logic writesHeld,
	input wire logic pinGuardActive,
	input wire logic programStart,
	input wire logic eraseStart,
	input wire logic [23:0] targetAddr,
	input wire logic cmdDiscarded,
	input wire logic cmdRefused
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	logic grant;
	assign grant = programStart || eraseStart;
	// top codes count down from the last block, bottom codes up from zero
	function automatic logic isProt(logic [3:0] c, logic [5:0] b);
		logic [6:0] bb;
		bb = {1'b0, b};
		if (c == 4'h0)
			return 1'b0;
		if (c < 4'h7)
			return bb >= 7'h40 - (7'h01 << (c - 4'h1));
		if (c > 4'h8 && c < 4'hF)
			return bb < 7'h40 - (7'h20 >> (c - 4'h9));
		return 1'b1;
	endfunction
	property p_held;
		writesHeld |-> !grant;
	endproperty
	a_held: assert property (p_held) else $error("grant while held");
	property p_latch;
		grant |-> $past(writeLatch, 2);
	endproperty
	a_latch: assert property (p_latch) else $error("grant, latch clear");
	property p_clear;
		grant |-> ##[0:2] !writeLatch;
	endproperty
	a_clear: assert property (p_clear) else $error("latch kept");
	property p_sleep;
		deepSleep |-> !grant;
	endproperty
	a_sleep: assert property (p_sleep) else $error("grant asleep");
	// one cycle later so a target register set with the pulse is seen
	property p_prot;
		grant && !otpMode |=> !isProt(blockProtectBits, targetAddr[21:16]);
	endproperty
	a_prot: assert property (p_prot) else $error("protected hit");
	property p_guard;
		(pinGuardActive && !protectPinOrDataLine2In) [*8]
			|=> $stable(blockProtectBits) && $stable(statusWriteGuard);
	endproperty
	a_guard: assert property (p_guard) else $error("guarded change");
	property p_quad;
		protectPinOrDataLine2Oe |-> !pinGuardActive && dataLine0Oe
			&& dataLine1Oe && sparePinOrDataLine3Oe;
	endproperty
	a_quad: assert property (p_quad) else $error("quad lines");
	property p_sticky;
		|securityBits |=> (securityBits | ~$past(securityBits)) == 2'h3;
	endproperty
	a_sticky: assert property (p_sticky) else $error("lock cleared");
	property p_factory;
		factoryLockStored [*6] |-> securityBits[SEC_FACTORY_BIT];
	endproperty
	a_factory: assert property (p_factory) else $error("no factory");
	property p_otp;
		otpMode |-> !eraseStart;
	endproperty
	a_otp: assert property (p_otp) else $error("wipe in otp");
	property p_pulse;
		cmdRefused |-> !cmdDiscarded && !grant ##1 !cmdRefused;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse clash");
endmodule

bind swp_write_protect swp_props swp_props_i (
	.mclk, .rst, .protectPinOrDataLine2In, .dataLine0Oe, .dataLine1Oe,
	.protectPinOrDataLine2Oe, .sparePinOrDataLine3Oe, .factoryLockStored,
	.writeLatch, .blockProtectBits, .statusWriteGuard, .securityBits,
	.otpMode, .deepSleep, .writesHeld, .pinGuardActive, .programStart,
	.eraseStart, .targetAddr, .cmdDiscarded, .cmdRefused
);

// *** verif/swp_host_model.sv ***
/*
 * Host serial master: sends one frame, mode 0, msb first.
 * Assumes the caller spaces frames; sclk stands low outside frames.
 */
module swp_host_model
(
	output logic sclk,
	output logic csN,
	output logic mosi
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk = 1'b0;
		mosi = 1'b0;
		// late, so the link flops see a clean rising chip select
		#1 csN = 1'b1;
	end
	// odd lead keeps sclk edges off the mclk grid
	task automatic frame(input logic [63:0] bits, input int n);
		csN = 1'b0;
		#43;
		for (int i = n - 1; i >= 0; i--) begin
			mosi = bits[i];
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
		end
		#80 csN = 1'b1;
		mosi = ~mosi;
	endtask
endmodule

// *** verif/test_serial_flash_write_protection.sv ***
/*
 * Testbench for swp_write_protect with a host model on the link.
 * Assumes a short power-up delay parameter for simulation.
 */
module test_serial_flash_write_protection
	import swp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PUW = 600;
	logic mclk, rst, sclk, csN, mosi, pinLevel;
	logic factoryLockStored, customerLockStored;
	logic dataLine0Out, dataLine0Oe, dataLine1Out, dataLine1Oe;
	logic protectPinOrDataLine2Out, protectPinOrDataLine2Oe;
	logic sparePinOrDataLine3Out, sparePinOrDataLine3Oe;
	logic writeLatch, statusWriteGuard, otpMode, deepSleep, writesHeld;
	logic pinGuardActive, programStart, eraseStart, otpTarget;
	logic cmdDiscarded, cmdRefused;
	logic [3:0] blockProtectBits, readNibble, res, oeSeen, quadNibble;
	logic [1:0] securityBits, eraseKind;
	logic [23:0] targetAddr;
	wire logic dataLine0In, dataLine1In;
	wire logic protectPinOrDataLine2In, sparePinOrDataLine3In;
	int badCount = 0;
	int compares = 0;
	int cycles = 0;
	// shared lines: device wins while enabled
	assign dataLine0In = dataLine0Oe ? dataLine0Out : mosi;
	assign dataLine1In = dataLine1Oe ? dataLine1Out : 1'b1;
	assign protectPinOrDataLine2In =
		protectPinOrDataLine2Oe ? protectPinOrDataLine2Out : pinLevel;
	assign sparePinOrDataLine3In =
		sparePinOrDataLine3Oe ? sparePinOrDataLine3Out : 1'b1;
	swp_host_model swp_host_model_i (.sclk, .csN, .mosi);
	swp_write_protect #(.PUW_CYCLE_COUNT(PUW)) swp_write_protect_i (
		.mclk, .rst, .sclk, .csN, .dataLine0In, .dataLine0Out, .dataLine0Oe,
		.dataLine1In, .dataLine1Out, .dataLine1Oe, .protectPinOrDataLine2In,
		.protectPinOrDataLine2Out, .protectPinOrDataLine2Oe,
		.sparePinOrDataLine3In, .sparePinOrDataLine3Out,
		.sparePinOrDataLine3Oe, .readNibble, .factoryLockStored,
		.customerLockStored, .writeLatch, .blockProtectBits, .statusWriteGuard,
		.securityBits, .otpMode, .deepSleep, .writesHeld, .pinGuardActive,
		.programStart, .eraseStart, .eraseKind, .otpTarget, .targetAddr,
		.cmdDiscarded, .cmdRefused
	);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		oeSeen <= oeSeen | {sparePinOrDataLine3Oe, protectPinOrDataLine2Oe,
			dataLine1Oe, dataLine0Oe};
		if (protectPinOrDataLine2Oe === 1'b1)
			quadNibble <= {sparePinOrDataLine3In, protectPinOrDataLine2In,
				dataLine1In, dataLine0In};
		if (cycles == 90000) begin
			badCount++;
			printVerdict();
		end
	end
	task automatic printVerdict();
		$display("compares %0d mismatches %0d", compares, badCount);
		if (badCount == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		compares++;
		if (got !== exp) begin
			badCount++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// res = {program, erase, refused, discarded} seen after the frame
	task automatic send(input logic [63:0] bits, input int n);
		swp_host_model_i.frame(bits, n);
		res = 4'h0;
		repeat (12) begin
			@(posedge mclk);
			#1;
			res |= {programStart, eraseStart, cmdRefused, cmdDiscarded};
		end
	endtask
	task automatic wrStatus(input logic [7:0] v);
		send(OP_WRITE_ALLOW, 8);
		send({OP_STATUS_WRITE, v}, 16);
	endtask
	task automatic tPower();
		check("idle", 0, {deepSleep, otpMode, writeLatch});
		check("held", 1, writesHeld);
		repeat (4) @(posedge mclk);
		#1;
		send(OP_WRITE_ALLOW, 8);
		send(OP_CHIP_WIPE, 8);
		check("early wipe", 4'h2, res);
		check("still held", 1, writesHeld);
		repeat (PUW) @(posedge mclk);
		#1;
		check("released", 0, writesHeld);
	endtask
	task automatic tLen();
		send(OP_WRITE_ALLOW >> 1, 7);
		check("7 bits", 4'h1, res);
		send({OP_WRITE_ALLOW, 1'b0}, 9);
		check("9 bits", 4'h1, res);
		send(OP_STATUS_WRITE, 8);
		check("short", 4'h1, res);
		send(OP_WRITE_ALLOW, 8);
		check("latch set", 1, writeLatch);
	endtask
	task automatic tLatch();
		logic [7:0] ops [7] = '{OP_WRITE_DISALLOW, OP_STATUS_WRITE,
			OP_PAGE_WRITE, OP_AUTO_INC_WRITE, OP_FOUR_K_WIPE, OP_BLOCK_WIPE,
			OP_CHIP_WIPE};
		logic [3:0] exp [7] = '{4'h0, 4'h0, 4'h8, 4'h8, 4'h4, 4'h4, 4'h4};
		for (int i = 0; i < 7; i++) begin
			send(OP_WRITE_ALLOW, 8);
			send({ops[i], 24'h000100}, 32);
			check("grant", exp[i], res);
			check("latch clear", 0, writeLatch);
			if (i == 2)
				check("addr", 24'h000100, targetAddr);
			if (i > 3)
				check("kind", i - 4, eraseKind);
		end
		send({OP_PAGE_WRITE, 24'h000100}, 32);
		check("no latch", 4'h2, res);
	endtask
	task automatic tProt();
		for (int c = 0; c < 16; c++) begin
			wrStatus({2'b00, c[3:0], 2'b00});
			check("code", c[3:0], blockProtectBits);
			send(OP_WRITE_ALLOW, 8);
			send({OP_BLOCK_WIPE, 24'h3F0000}, 32);
			check("top", (c > 0 && c < 9) || c == 15 ? 2 : 4, res);
			send(OP_WRITE_ALLOW, 8);
			send({OP_BLOCK_WIPE, 24'h000000}, 32);
			check("bottom", c > 6 ? 2 : 4, res);
		end
		wrStatus(8'h00);
	endtask
	task automatic tGuard();
		wrStatus(8'h84);
		check("guard on", 1, pinGuardActive);
		pinLevel = 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		wrStatus(8'h00);
		check("guarded", {1'b1, 4'h1}, {statusWriteGuard, blockProtectBits});
		oeSeen = 4'h0;
		send({OP_QUAD_READ, 24'h000000, 16'h0000}, 48);
		check("quad lines", 4'hF, oeSeen);
		check("quad data", 4'hA, quadNibble);
		oeSeen = 4'h0;
		send({OP_DUAL_READ, 32'h00000000}, 40);
		check("dual lines", 4'h3, oeSeen);
		oeSeen = 4'h0;
		send({OP_READ, 32'h00000000}, 40);
		check("read line", 4'h2, oeSeen);
		pinLevel = 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		wrStatus(8'h00);
		check("unguarded", 0, {statusWriteGuard, blockProtectBits});
	endtask
	task automatic tSleep();
		send(OP_SLEEP, 8);
		check("asleep", 1, deepSleep);
		send(OP_WRITE_ALLOW, 8);
		check("filtered", 4'h1, res);
		send(OP_WAKE, 8);
		check("awake", 0, {deepSleep, writeLatch});
	endtask
	task automatic tOtp();
		send(OP_OTP_ENTRY, 8);
		check("otp on", 1, otpMode);
		send(OP_WRITE_ALLOW, 8);
		send({OP_BLOCK_WIPE, 24'h000000}, 32);
		check("array", 4'h2, res);
		send({OP_PAGE_WRITE, 24'h000010}, 32);
		check("otp prog", 4'h8, res);
		check("otp target", 1, otpTarget);
		send(OP_WRITE_ALLOW, 8);
		send(OP_SEC_REG_WRITE, 8);
		check("cust lock", 2'h2, securityBits);
		send({OP_PAGE_WRITE, 24'h0001FF}, 32);
		check("cust area", 4'h2, res);
		send({OP_PAGE_WRITE, 24'h00000F}, 32);
		check("serial area", 4'h8, res);
		factoryLockStored = 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		check("factory", 2'h3, securityBits);
		send(OP_WRITE_ALLOW, 8);
		send({OP_PAGE_WRITE, 24'h000000}, 32);
		check("serial lock", 4'h2, res);
		factoryLockStored = 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		check("sticky", 2'h3, securityBits);
		send(OP_OTP_EXIT, 8);
		check("otp off", 0, otpMode);
	endtask
	initial begin
		// late, so the link toggle sees a clean rising reset
		#1;
		rst = 1'b1;
		pinLevel = 1'b1;
		oeSeen = 4'h0;
		factoryLockStored = 1'b0;
		customerLockStored = 1'b0;
		readNibble = 4'hA;
		repeat (2) @(posedge mclk);
		#1;
		rst = 1'b0;
		tPower();
		tLen();
		tLatch();
		tProt();
		tGuard();
		tSleep();
		tOtp();
		printVerdict();
	end
endmodule
